// ### common/ljlm_defines.vh
/*
 Timing counts, register offsets, field positions and reset values of the
 port supervision block. Assumes a 10 MHz core clock.
*/
`ifndef LJLM_DEFINES_VH
`define LJLM_DEFINES_VH
`define LJLM_CLK_HZ 10000000
`define LJLM_LAMP_TEST_MS 1000
`define LJLM_BLINK_MS 100
`define LJLM_LINK_LOSS_MS 100
`define LJLM_JABBER_MS 20
`define LJLM_UNJAB_MS 500
`define LJLM_MS_CYC (`LJLM_CLK_HZ / 1000)
`define LJLM_LAMP_TEST_CYC (`LJLM_LAMP_TEST_MS * `LJLM_MS_CYC)
`define LJLM_BLINK_CYC (`LJLM_BLINK_MS * `LJLM_MS_CYC)
`define LJLM_LINK_LOSS_CYC (`LJLM_LINK_LOSS_MS * `LJLM_MS_CYC)
`define LJLM_JABBER_CYC (`LJLM_JABBER_MS * `LJLM_MS_CYC)
`define LJLM_UNJAB_CYC (`LJLM_UNJAB_MS * `LJLM_MS_CYC)
`define LJLM_ADDR_CONFIG 4'h0
`define LJLM_ADDR_STATUS 4'h1
`define LJLM_ADDR_IRQ_STAT 4'h2
`define LJLM_ADDR_IRQ_MASK 4'h3
`define LJLM_CFG_LINK_TEST_OFF 14
`define LJLM_CFG_JABBER_OFF 10
`define LJLM_CFG_AUTONEG_EN 12
`define LJLM_STAT_LINK 2
`define LJLM_STAT_JABBER 1
`define LJLM_IRQ_LINK_UP 0
`define LJLM_IRQ_LINK_FAIL 1
`define LJLM_IRQ_JABBER 2
`define LJLM_CONFIG_RST 16'h1000
`define LJLM_IRQ_MASK_RST 16'h0000
`endif

// ### logic/ljlm_sync.v
/*
 Two-stage synchroniser for a vector of pin levels.
 Assumes the inputs are asynchronous to clk.
*/
`timescale 1ns/1ps
module ljlm_sync #(
    parameter W = 1
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Levels
    input wire [W-1:0] asyncIn,
    output reg [W-1:0] syncOut
);
    reg [W-1:0] stage1_r;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_r <= {W{1'b0}};
            syncOut <= {W{1'b0}};
        end else begin
            stage1_r <= asyncIn;
            syncOut <= stage1_r;
        end
    end
endmodule

// ### logic/ljlm_port_monitor.v
/*
 One port's 10BASE-T link supervision, jabber guard and LED driver.
 Assumes pin inputs are asynchronous; register port on core_clk.
*/
// The address map and the strobed register port are this design's own decisions.
// Operation
// - Link test on: no pulses or packets declares failure, back to autoneg
// - Overlong transmission enters jabber, disabling transmit and loopback
// - Jabber mode ends by itself after the unjab interval
// - Config bit 16.10 set disables the jabber guard
// - Status bit 1.2 reads one once link is established
// - Three LEDs per port, all lit about one second after reset
// - Select pins choose LED meanings per the four-entry table
// - Modes two and four blink combined indications at 100 ms
// - Config bit 16.14 set disables link test, transmit allowed without link
`timescale 1ns/1ps
`include "ljlm_defines.vh"
module ljlm_port_monitor (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Register port
    input wire [3:0] regAddr,
    input wire [15:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [15:0] regRdata,
    output reg irq,
    // Line and MAC status pins
    input wire linkPulse,
    input wire rxActive,
    input wire txRequest,
    input wire loopbackRequest,
    input wire speed100,
    input wire fullDuplex,
    input wire collision,
    input wire miiIsolate,
    input wire led_select_low,
    input wire led_select_high,
    // Datapath gates
    output reg txEnable,
    output reg loopbackEnable,
    output reg autonegRestart,
    // Lamps
    output reg port_lamp_first_o,
    output reg port_lamp_first_oe_n,
    output reg port_lamp_second_o,
    output reg port_lamp_second_oe_n,
    output reg port_lamp_third_o,
    output reg port_lamp_third_oe_n
);
    localparam ST_DOWN = 2'b01;
    localparam ST_UP = 2'b10;

    wire [9:0] pinSync;
    reg [15:0] config_r;
    reg [15:0] irqStat_r;
    reg [15:0] irqMask_r;
    reg [1:0] linkState_r;
    reg [20:0] silenceCnt_r;
    reg jabber_r;
    reg [23:0] jabCnt_r;
    reg [23:0] lampCnt_r;
    reg lampTest_r;
    reg [19:0] blinkCnt_r;
    reg blink_r;
    reg linkPulseD_r;
    reg [2:0] lampOn;
    reg [15:0] irqSet;
    reg [15:0] irqStatNxt;

    wire pulseIn = pinSync[0];
    wire rxIn = pinSync[1];
    wire txIn = pinSync[2];
    wire loopIn = pinSync[3];
    wire spdIn = pinSync[4];
    wire dupIn = pinSync[5];
    wire colIn = pinSync[6];
    wire isoIn = pinSync[7];
    wire selLo = pinSync[8];
    wire selHi = pinSync[9];
    wire linkTestOff = config_r[`LJLM_CFG_LINK_TEST_OFF];
    wire jabberOff = config_r[`LJLM_CFG_JABBER_OFF];
    wire autonegEn = config_r[`LJLM_CFG_AUTONEG_EN];
    wire linkUp = (linkState_r == ST_UP);
    wire activity = rxIn | txIn;
    wire pulseSeen = pulseIn & ~linkPulseD_r;
    wire silenceDone = (silenceCnt_r == (`LJLM_LINK_LOSS_CYC - 1));
    wire linkFail = linkUp & ~linkTestOff & silenceDone & ~pulseSeen & ~rxIn;
    wire jabEnter = ~jabber_r & ~jabberOff & txIn & (jabCnt_r == (`LJLM_JABBER_CYC - 1));
    wire jabLeave = jabber_r & (jabberOff | (jabCnt_r == (`LJLM_UNJAB_CYC - 1)));

    // Pins cross into core_clk before any use
    ljlm_sync #(.W(10)) pinSyncU (
        .clk(core_clk),
        .rst_n(rst_n),
        .asyncIn({led_select_high, led_select_low, miiIsolate, collision, fullDuplex,
                  speed100, loopbackRequest, txRequest, rxActive, linkPulse}),
        .syncOut(pinSync)
    );

    // Link state and silence timer
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            linkState_r <= ST_DOWN;
            silenceCnt_r <= 21'h0;
            linkPulseD_r <= 1'b0;
            autonegRestart <= 1'b0;
        end else begin
            linkPulseD_r <= pulseIn;
            autonegRestart <= 1'b0;
            if (pulseSeen | rxIn) begin
                silenceCnt_r <= 21'h0;
            end else if (!silenceDone) begin
                silenceCnt_r <= silenceCnt_r + 21'h1;
            end
            case (linkState_r)
                ST_DOWN: begin
                    if (pulseSeen | rxIn | linkTestOff) begin
                        linkState_r <= ST_UP;
                    end
                end
                ST_UP: begin
                    if (linkFail) begin
                        linkState_r <= ST_DOWN;
                        autonegRestart <= autonegEn;
                    end
                end
                default: begin
                    linkState_r <= ST_DOWN;
                end
            endcase
        end
    end

    // Jabber timer doubles as unjab timer
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            jabber_r <= 1'b0;
            jabCnt_r <= 24'h0;
        end else if (jabEnter) begin
            jabber_r <= 1'b1;
            jabCnt_r <= 24'h0;
        end else if (jabLeave) begin
            jabber_r <= 1'b0;
            jabCnt_r <= 24'h0;
        end else if (jabber_r) begin
            jabCnt_r <= jabCnt_r + 24'h1;
        end else if (txIn & ~jabberOff) begin
            jabCnt_r <= jabCnt_r + 24'h1;
        end else begin
            jabCnt_r <= 24'h0;
        end
    end

    // Datapath gates
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            txEnable <= 1'b0;
            loopbackEnable <= 1'b0;
        end else begin
            txEnable <= txIn & ~jabber_r & ~jabEnter & (linkUp | linkTestOff);
            loopbackEnable <= loopIn & ~jabber_r & ~jabEnter;
        end
    end

    // Lamp test and blink timebase
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lampCnt_r <= 24'h0;
            lampTest_r <= 1'b1;
            blinkCnt_r <= 20'h0;
            blink_r <= 1'b0;
        end else begin
            if (lampTest_r) begin
                if (lampCnt_r == (`LJLM_LAMP_TEST_CYC - 1)) begin
                    lampTest_r <= 1'b0;
                end else begin
                    lampCnt_r <= lampCnt_r + 24'h1;
                end
            end
            if (blinkCnt_r == (`LJLM_BLINK_CYC - 1)) begin
                blinkCnt_r <= 20'h0;
                blink_r <= ~blink_r;
            end else begin
                blinkCnt_r <= blinkCnt_r + 20'h1;
            end
        end
    end

    always @* begin
        case ({selHi, selLo})
            2'b00: lampOn = {dupIn, linkUp, spdIn};
            2'b01: lampOn = {(colIn ? blink_r : dupIn), (activity ? (linkUp & blink_r) : linkUp),
                             spdIn};
            2'b10: lampOn = {txIn, rxIn, linkUp};
            2'b11: lampOn = {(colIn ? blink_r : dupIn), (isoIn ? blink_r : linkUp), spdIn};
            default: lampOn = 3'b000;
        endcase
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_lamp_first_o <= 1'b0;
            port_lamp_second_o <= 1'b0;
            port_lamp_third_o <= 1'b0;
            port_lamp_first_oe_n <= 1'b1;
            port_lamp_second_oe_n <= 1'b1;
            port_lamp_third_oe_n <= 1'b1;
        end else begin
            port_lamp_first_oe_n <= ~(lampTest_r | lampOn[0]);
            port_lamp_second_oe_n <= ~(lampTest_r | lampOn[1]);
            port_lamp_third_oe_n <= ~(lampTest_r | lampOn[2]);
        end
    end

    // Sticky events, set beats clear
    always @* begin
        irqSet = 16'h0;
        irqSet[`LJLM_IRQ_LINK_UP] = (linkState_r == ST_DOWN) & (pulseSeen | rxIn | linkTestOff);
        irqSet[`LJLM_IRQ_LINK_FAIL] = linkFail;
        irqSet[`LJLM_IRQ_JABBER] = jabEnter;
        irqStatNxt = irqStat_r;
        if (regWr && regAddr == `LJLM_ADDR_IRQ_STAT) begin
            irqStatNxt = irqStat_r & ~regWdata;
        end
        irqStatNxt = irqStatNxt | irqSet;
    end

    // Register port
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            config_r <= `LJLM_CONFIG_RST;
            irqMask_r <= `LJLM_IRQ_MASK_RST;
            irqStat_r <= 16'h0;
            regRdata <= 16'h0;
            irq <= 1'b0;
        end else begin
            irqStat_r <= irqStatNxt;
            irq <= |(irqStatNxt & irqMask_r);
            if (regWr && regAddr == `LJLM_ADDR_CONFIG) begin
                config_r <= regWdata;
            end
            if (regWr && regAddr == `LJLM_ADDR_IRQ_MASK) begin
                irqMask_r <= regWdata;
            end
            regRdata <= 16'h0;
            if (regRd) begin
                case (regAddr)
                    `LJLM_ADDR_CONFIG: regRdata <= config_r;
                    `LJLM_ADDR_STATUS: regRdata <= {13'h0, linkUp, jabber_r, 1'b0};
                    `LJLM_ADDR_IRQ_STAT: regRdata <= irqStat_r;
                    `LJLM_ADDR_IRQ_MASK: regRdata <= irqMask_r;
                    default: regRdata <= 16'h0;
                endcase
            end
        end
    end
endmodule

// ### dv/ljlm_checker_assertions.sv
/*
 Checker for the port monitor top ports.
 Assumes a bind onto ljlm_port_monitor, one core_clk domain.
*/
`timescale 1ns/1ps
`include "ljlm_defines.vh"
module ljlm_checker (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Register port
    input wire [3:0] regAddr,
    input wire [15:0] regWdata,
    input wire regWr,
    input wire regRd,
    input wire [15:0] regRdata,
    input wire irq,
    // Gates
    input wire txRequest,
    input wire loopbackRequest,
    input wire txEnable,
    input wire loopbackEnable,
    input wire autonegRestart,
    // Lamps
    input wire port_lamp_first_o,
    input wire port_lamp_second_o,
    input wire port_lamp_third_o,
    input wire port_lamp_first_oe_n,
    input wire port_lamp_second_oe_n,
    input wire port_lamp_third_oe_n
);
    reg [15:0] upCnt_r;
    reg [15:0] cfg_r;
    reg [15:0] mask_r;
    wire allLit = !(port_lamp_first_oe_n | port_lamp_second_oe_n | port_lamp_third_oe_n);
    wire anyHigh = port_lamp_first_o | port_lamp_second_o | port_lamp_third_o;
    // Saturates, lamp test is far longer than this
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            upCnt_r <= 16'h0;
            cfg_r <= `LJLM_CONFIG_RST;
            mask_r <= 16'h0;
        end else begin
            if (upCnt_r != 16'hffff) upCnt_r <= upCnt_r + 16'h1;
            if (regWr && regAddr == `LJLM_ADDR_CONFIG) cfg_r <= regWdata;
            if (regWr && regAddr == `LJLM_ADDR_IRQ_MASK) mask_r <= regWdata;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    lamp_test_lit_a: assert property (upCnt_r != 16'h0 && upCnt_r != 16'hffff |-> allLit)
        else $error("lamps dark during lamp test");
    lamp_drive_low_a: assert property (!anyHigh)
        else $error("lamp driven high");
    tx_gate_a: assert property (txEnable |-> $past(txRequest, 3) || $past(txRequest, 4))
        else $error("transmit enabled without request");
    loop_gate_a: assert property (loopbackEnable |-> $past(loopbackRequest, 3))
        else $error("loopback enabled without request");
    status_layout_a: assert property (regRd && regAddr == 4'h1 |=> !(regRdata & 16'hfff9))
        else $error("status word has stray bits");
    rdata_idle_a: assert property (!regRd |=> regRdata == 16'h0)
        else $error("read data outside read slot");
    irq_mask_a: assert property (irq |-> $past(mask_r) != 16'h0)
        else $error("interrupt with all sources masked");
    autoneg_pulse_a: assert property (autonegRestart |=> !autonegRestart)
        else $error("restart pulse too long");
    autoneg_cfg_a: assert property (autonegRestart |-> $past(cfg_r[12]))
        else $error("restart while negotiation off");
    cover property (regRd && regAddr == 4'h1);
    cover property ($rose(irq));
    cover property ($rose(txEnable));
endmodule
bind ljlm_port_monitor ljlm_checker chk (.core_clk, .rst_n, .regAddr, .regWdata, .regWr,
    .regRd, .regRdata, .irq, .txRequest, .loopbackRequest, .txEnable, .loopbackEnable,
    .autonegRestart, .port_lamp_first_o, .port_lamp_second_o, .port_lamp_third_o,
    .port_lamp_first_oe_n, .port_lamp_second_oe_n, .port_lamp_third_oe_n);

// ### dv/ljlm_link_partner.sv
/*
 Link partner and lamp board model.
 Assumes core_clk timing; lamps pulled up on the board.
*/
`timescale 1ns/1ps
module ljlm_link_partner (
    // Clock and control
    input wire core_clk,
    input wire pulseOn,
    // Line
    output reg linkPulse,
    // Lamps
    input wire [2:0] lampO,
    input wire [2:0] lampOeN,
    output wire [2:0] lampPin
);
    reg [3:0] gap_r = 4'h0;
    initial linkPulse = 1'b0;
    assign lampPin = lampOeN | lampO;
    // Short gaps keep the run brief
    always @(posedge core_clk) begin
        gap_r <= gap_r + 4'h1;
        linkPulse <= pulseOn && gap_r == 4'hf;
    end
endmodule

// ### dv/link_jabber_led_monitor_bench.sv
/*
 Self-checking bench of the port monitor.
 Assumes the checker is bound and the partner model is present.
*/
`timescale 1ns/1ps
module link_jabber_led_monitor_bench;
    reg core_clk = 1'b0;
    reg rst_n = 1'b0;
    reg [3:0] regAddr = 4'h0;
    reg [15:0] regWdata = 16'h0;
    reg regWr = 1'b0, regRd = 1'b0, rxActive = 1'b0, txRequest = 1'b0, pulseOn = 1'b0;
    reg loopbackRequest = 1'b0;
    reg [3:0] misc = 4'h0;
    reg [1:0] sel = 2'h0;
    wire [15:0] regRdata;
    wire irq, linkPulse, txEnable, loopbackEnable;
    wire [2:0] lampO, lampOeN, lampPin;
    integer errorCnt = 0, checked = 0, cyc = 0, i;
    always #50 core_clk = ~core_clk;
    ljlm_port_monitor DUT (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq),
        .linkPulse(linkPulse), .rxActive(rxActive), .txRequest(txRequest),
        .loopbackRequest(loopbackRequest), .speed100(misc[0]), .fullDuplex(misc[1]),
        .collision(misc[2]), .miiIsolate(misc[3]), .led_select_low(sel[0]),
        .led_select_high(sel[1]), .txEnable(txEnable), .loopbackEnable(loopbackEnable),
        .autonegRestart(), .port_lamp_first_o(lampO[0]), .port_lamp_first_oe_n(lampOeN[0]),
        .port_lamp_second_o(lampO[1]), .port_lamp_second_oe_n(lampOeN[1]),
        .port_lamp_third_o(lampO[2]), .port_lamp_third_oe_n(lampOeN[2]));
    ljlm_link_partner peer (.core_clk(core_clk), .pulseOn(pulseOn), .linkPulse(linkPulse),
        .lampO(lampO), .lampOeN(lampOeN), .lampPin(lampPin));
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                errorCnt = errorCnt + 1;
                $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
            end
        end
    endtask
    task settle(input integer n);
        begin
            repeat (n) @(posedge core_clk);
            #1;
        end
    endtask
    task wr(input [3:0] a, input [15:0] d);
        begin
            @(posedge core_clk);
            regWr <= 1'b1;
            regAddr <= a;
            regWdata <= d;
            @(posedge core_clk);
            regWr <= 1'b0;
        end
    endtask
    // Read data stand only in the cycle after the strobe
    task rd(input [3:0] a, input [15:0] exp);
        begin
            @(posedge core_clk);
            regRd <= 1'b1;
            regAddr <= a;
            @(posedge core_clk);
            regRd <= 1'b0;
            #1;
            chk(regRdata, exp);
        end
    endtask
    task closeOut;
        begin
            $display("Checks %0d, errors %0d", checked, errorCnt);
            if (errorCnt == 0 && checked > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    // Whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errorCnt = errorCnt + 1;
            closeOut;
        end
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(4'h0, 16'h1000);
        rd(4'h1, 16'h0000);
        wr(4'h7, 16'hffff);
        rd(4'h7, 16'h0000);
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge core_clk);
            sel <= i[1:0];
            misc <= i[3:0] ^ 4'hf;
            settle(4);
            chk({13'h0, lampPin}, 16'h0000);
        end
        @(posedge core_clk);
        txRequest <= 1'b1;
        settle(10);
        chk({15'h0, txEnable}, 16'h0000);
        @(posedge core_clk);
        pulseOn <= 1'b1;
        loopbackRequest <= 1'b1;
        settle(40);
        rd(4'h1, 16'h0004);
        chk({14'h0, txEnable, loopbackEnable}, 16'h0003);
        rd(4'h2, 16'h0001);
        chk({15'h0, irq}, 16'h0000);
        wr(4'h3, 16'h0001);
        settle(3);
        chk({15'h0, irq}, 16'h0001);
        wr(4'h2, 16'h0001);
        settle(3);
        chk({15'h0, irq}, 16'h0000);
        rd(4'h2, 16'h0000);
        wr(4'h1, 16'h0000);
        rd(4'h1, 16'h0004);
        wr(4'h0, 16'h5400);
        rd(4'h0, 16'h5400);
        pulseOn <= 1'b0;
        settle(40);
        rd(4'h1, 16'h0004);
        chk({15'h0, txEnable}, 16'h0001);
        // Mid-run reset: lamps released in reset, lamp test restarts, link drops
        @(posedge core_clk);
        rst_n <= 1'b0;
        settle(3);
        chk({13'h0, lampPin}, 16'h0007);
        chk({15'h0, txEnable}, 16'h0000);
        @(posedge core_clk);
        rst_n <= 1'b1;
        settle(2);
        chk({13'h0, lampPin}, 16'h0000);
        rd(4'h1, 16'h0000);
        settle(10);
        // No pulses since before reset, so only the bypass can open transmit
        chk({14'h0, txEnable, loopbackEnable}, 16'h0001);
        wr(4'h0, 16'h4000);
        settle(3);
        chk({14'h0, txEnable, loopbackEnable}, 16'h0003);
        rd(4'h2, 16'h0001);
        closeOut;
    end
endmodule
